// [logic/tw8_wave_ctrl.sv]
// design: 8-bit timer waveform mode control with axi4-lite register slave
// ------------------------------------------------------------
// What this block does
// - nonzero channel a action routes output to pin, except 01 in pwm with top bit clear and any action in reserved modes
// - pin driver enabled only with direction bit set
// - non-pwm a: off, toggle, clear, set on match
// - fast pwm a: clear/set at match/bottom, 01 by top
// - fast pwm compare equals top: act at bottom
// - phase pwm a equals top: act at top
// - phase pwm a: clear up, set down, or reverse
// - non-pwm b uses same encoding as a
// - fast pwm b: 01 reserved, 10/11 as a
// - phase pwm b: 01 reserved, up/down actions
// - nonzero channel b action routes output to pin, except 01 in pwm modes and any action in reserved modes
// - control a bits 3 and 2 read as zero
// - mode from two low bits plus top bit
// - decode modes, top 0xff or compare a
// - compare buffer update immediate, top or bottom
// - overflow flag at max, bottom or top
// - phase pwm b equals top: act at top
// - each compare value matched against counter continuously
// ------------------------------------------------------------
`timescale 1ns/1ps
module tw8_wave_ctrl (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic count_tick,
	output tw8_pkg::tw8_pin_s pin_a,
	output tw8_pkg::tw8_pin_s pin_b,
	output tw8_pkg::tw8_evt_s events
);
	import tw8_pkg::*;

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic [7:0] ctrl_a_q, ctrl_b_q, cmp_a_q, cmp_b_q, buf_a_q, buf_b_q, count_q, port_q;
	logic [2:0] flags_q;
	logic dir_up_q, oc_a_q, oc_b_q;
	logic aw_q, w_q, bvalid_q, rvalid_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	wire [1:0] chan_a_output_action = ctrl_a_q[TW8_CA_ACT_A_LSB +: 2];
	wire [1:0] chan_b_output_action = ctrl_a_q[TW8_CA_ACT_B_LSB +: 2];
	wire chan_a_action_high = chan_a_output_action[1];
	wire chan_b_action_high = chan_b_output_action[1];
	wire waveform_mode_top_bit = ctrl_b_q[TW8_CB_TOP_BIT];
	wire [1:0] waveform_mode_low = ctrl_a_q[TW8_CA_WAVE_LSB +: 2];
	tw8_wave_mode_e waveform_mode_sel;
	assign waveform_mode_sel = tw8_wave_mode_e'({waveform_mode_top_bit, waveform_mode_low});
	wire is_normal = (waveform_mode_sel == TW8_WM_NORMAL);
	wire is_clr_match = (waveform_mode_sel == TW8_WM_CLR_MATCH);
	wire is_fast = (waveform_mode_sel == TW8_WM_FAST_FF) || (waveform_mode_sel == TW8_WM_FAST_CMPA);
	wire is_phase = (waveform_mode_sel == TW8_WM_PC_FF) || (waveform_mode_sel == TW8_WM_PC_CMPA);
	wire is_res = (waveform_mode_sel == TW8_WM_RES4) || (waveform_mode_sel == TW8_WM_RES6);
	wire top_from_a = is_clr_match || waveform_mode_sel[2];
	wire [7:0] top_val = top_from_a ? cmp_a_q : TW8_MAX;
	wire run = ctrl_b_q[TW8_CB_CLKEN_BIT] && count_tick && !is_res;

	// counter datapath is minimal: only what the waveform decode needs
	wire at_top = (count_q == top_val);
	wire at_bottom = (count_q == TW8_BOTTOM);
	wire at_max = (count_q == TW8_MAX);
	wire match_a = (count_q == cmp_a_q);
	wire match_b = (count_q == cmp_b_q);
	wire turn_down = is_phase && dir_up_q && at_top;
	wire turn_up = is_phase && !dir_up_q && at_bottom;
	wire cnt_up = is_phase ? ((dir_up_q && !at_top) || turn_up) : 1'b1;
	wire wrap = (is_clr_match || is_fast || is_normal) && at_top;
	wire [7:0] count_d = wrap ? TW8_BOTTOM : (cnt_up ? count_q + 8'h01 : count_q - 8'h01);

	// buffered compare load point
	wire load_cmp = (is_normal || is_clr_match) ? 1'b1 : (is_phase ? at_top : (is_fast ? wrap : 1'b0));
	wire ovf = ((is_normal || is_clr_match || waveform_mode_sel == TW8_WM_FAST_FF) && at_max)
		|| (is_phase && at_bottom)
		|| ((waveform_mode_sel == TW8_WM_FAST_CMPA) && at_top);

	// ------------------------------------------------------------
	// compare output action per channel
	// ------------------------------------------------------------
	// 2'b01 in pwm: channel a toggles only with top bit, channel b reserved
	wire a_tog_ok = !(is_fast || is_phase) || waveform_mode_top_bit;
	wire b_tog_ok = !(is_fast || is_phase);
	wire con_a = (chan_a_output_action != 2'b00) && !is_res && (chan_a_action_high || a_tog_ok);
	wire con_b = (chan_b_output_action != 2'b00) && !is_res && (chan_b_action_high || b_tog_ok);

	function automatic logic next_oc(
		input logic cur,
		input logic [1:0] act,
		input logic hit,
		input logic cmp_is_top
	);
		logic r;
		r = cur;
		if (act == 2'b01) begin
			if (hit) begin
				r = !cur;
			end
		end else if (act[1]) begin
			if (is_fast) begin
				if (hit && !cmp_is_top) begin
					r = act[0];
				end
				if (at_bottom) begin
					r = !act[0];
				end
			end else if (is_phase) begin
				if (cmp_is_top) begin
					if (at_top) begin
						r = dir_up_q ? !act[0] : act[0];
					end
				end else if (hit) begin
					r = (dir_up_q ^ turn_up) ? act[0] : !act[0];
				end
			end else if (hit) begin
				r = act[0];
			end
		end
		return r;
	endfunction : next_oc

	wire a_eq_top = (cmp_a_q == top_val);
	wire b_eq_top = (cmp_b_q == top_val);
	wire oc_a_d = next_oc(oc_a_q, chan_a_output_action, match_a, a_eq_top && chan_a_action_high);
	wire oc_b_d = next_oc(oc_b_q, chan_b_output_action, match_b, b_eq_top && chan_b_action_high);

	// ------------------------------------------------------------
	// axi4-lite decode
	// ------------------------------------------------------------
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire do_write = aw_q && w_q && !bvalid_q;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	wire wr_lane0 = do_write && wstrb_q[0];
	wire wr_ca = wr_lane0 && (awaddr_q == TW8_OFF_CTRL_A);
	wire wr_cb = wr_lane0 && (awaddr_q == TW8_OFF_CTRL_B);
	wire wr_cmpa = wr_lane0 && (awaddr_q == TW8_OFF_CMP_A);
	wire wr_cmpb = wr_lane0 && (awaddr_q == TW8_OFF_CMP_B);
	wire wr_cnt = wr_lane0 && (awaddr_q == TW8_OFF_COUNT);
	wire wr_stat = wr_lane0 && (awaddr_q == TW8_OFF_STATUS);
	wire wr_port = wr_lane0 && (awaddr_q == TW8_OFF_PORT);
	wire wr_known = (awaddr_q == TW8_OFF_CTRL_A) || (awaddr_q == TW8_OFF_CTRL_B) || (awaddr_q == TW8_OFF_CMP_A)
		|| (awaddr_q == TW8_OFF_CMP_B) || (awaddr_q == TW8_OFF_COUNT) || (awaddr_q == TW8_OFF_STATUS)
		|| (awaddr_q == TW8_OFF_PORT);

	logic [7:0] rd_byte;
	logic rd_ok;
	always_comb begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
			TW8_OFF_CTRL_A: rd_byte = ctrl_a_q & TW8_CA_WMASK;
			TW8_OFF_CTRL_B: rd_byte = ctrl_b_q & TW8_CB_WMASK;
			TW8_OFF_CMP_A: rd_byte = buf_a_q;
			TW8_OFF_CMP_B: rd_byte = buf_b_q;
			TW8_OFF_COUNT: rd_byte = count_q;
			TW8_OFF_STATUS: rd_byte = {1'b0, oc_b_q, oc_a_q, dir_up_q, 1'b0, flags_q};
			TW8_OFF_PORT: rd_byte = port_q;
			default: begin
				rd_byte = 8'h00;
				rd_ok = 1'b0;
			end
		endcase
	end

	assign s_axi_awready = !aw_q && !bvalid_q;
	assign s_axi_wready = !w_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// ------------------------------------------------------------
	// bus handshake
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			bvalid_q <= 1'b0;
			rvalid_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bresp_q <= TW8_RESP_OKAY;
			rdata_q <= 32'h0000_0000;
			rresp_q <= TW8_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				w_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_known ? TW8_RESP_OKAY : TW8_RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
			if (ar_take) begin
				rvalid_q <= 1'b1;
				rdata_q <= {24'h00_0000, rd_byte};
				rresp_q <= rd_ok ? TW8_RESP_OKAY : TW8_RESP_SLVERR;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// control, compare and waveform state
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_a_q <= TW8_CTRL_RESET;
			ctrl_b_q <= TW8_CTRL_RESET;
			cmp_a_q <= 8'h00;
			cmp_b_q <= 8'h00;
			buf_a_q <= 8'h00;
			buf_b_q <= 8'h00;
			count_q <= 8'h00;
			port_q <= 8'h00;
			flags_q <= 3'b000;
			dir_up_q <= 1'b1;
			oc_a_q <= 1'b0;
			oc_b_q <= 1'b0;
		end else begin
			if (wr_ca) ctrl_a_q <= wdata_q[7:0] & TW8_CA_WMASK;
			if (wr_cb) ctrl_b_q <= wdata_q[7:0] & TW8_CB_WMASK;
			if (wr_cmpa) buf_a_q <= wdata_q[7:0];
			if (wr_cmpb) buf_b_q <= wdata_q[7:0];
			if (wr_port) port_q <= wdata_q[7:0];
			// immediate modes track the buffer even while stopped
			if ((is_normal || is_clr_match) || (run && load_cmp)) begin
				cmp_a_q <= buf_a_q;
				cmp_b_q <= buf_b_q;
			end
			if (wr_cnt) begin
				count_q <= wdata_q[7:0];
			end else if (run) begin
				count_q <= count_d;
				if (turn_down) dir_up_q <= 1'b0;
				if (turn_up) dir_up_q <= 1'b1;
				oc_a_q <= oc_a_d;
				oc_b_q <= oc_b_d;
			end
			if (!is_phase) dir_up_q <= 1'b1;
			// set wins over a write-one clear in the same cycle
			flags_q <= (flags_q & ~(wr_stat ? wdata_q[2:0] : 3'b000))
				| (run ? {match_b, match_a, ovf} : 3'b000);
		end
	end

	// ------------------------------------------------------------
	// pin outputs
	// ------------------------------------------------------------
	assign pin_a.connect = con_a;
	assign pin_a.level = con_a ? oc_a_q : port_q[0];
	assign pin_a.enable = port_q[4];
	assign pin_b.connect = con_b;
	assign pin_b.level = con_b ? oc_b_q : port_q[1];
	assign pin_b.enable = port_q[5];
	assign events.overflow_flag = flags_q[0];
	assign events.match_a = flags_q[1];
	assign events.match_b = flags_q[2];

endmodule : tw8_wave_ctrl

// [common/tw8_pkg.sv]
// package: register map, field layout and mode encodings of the 8-bit timer waveform control
package tw8_pkg;

	// ------------------------------------------------------------
	// register byte addresses (axi4-lite, one word each)
	// ------------------------------------------------------------
	localparam logic [7:0] TW8_OFF_CTRL_A = 8'h00;
	localparam logic [7:0] TW8_OFF_CTRL_B = 8'h04;
	localparam logic [7:0] TW8_OFF_CMP_A = 8'h08;
	localparam logic [7:0] TW8_OFF_CMP_B = 8'h0C;
	localparam logic [7:0] TW8_OFF_COUNT = 8'h10;
	localparam logic [7:0] TW8_OFF_STATUS = 8'h14;
	localparam logic [7:0] TW8_OFF_PORT = 8'h18;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int TW8_CA_ACT_A_LSB = 6;
	localparam int TW8_CA_ACT_B_LSB = 4;
	localparam int TW8_CA_WAVE_LSB = 0;
	localparam int TW8_CB_TOP_BIT = 3;
	localparam int TW8_CB_CLKEN_BIT = 0;
	localparam logic [7:0] TW8_CA_WMASK = 8'hF3;
	localparam logic [7:0] TW8_CB_WMASK = 8'h09;
	localparam logic [7:0] TW8_CTRL_RESET = 8'h00;
	localparam logic [7:0] TW8_MAX = 8'hFF;
	localparam logic [7:0] TW8_BOTTOM = 8'h00;
	localparam logic [1:0] TW8_RESP_OKAY = 2'b00;
	localparam logic [1:0] TW8_RESP_SLVERR = 2'b10;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		TW8_WM_NORMAL = 3'b000,
		TW8_WM_PC_FF = 3'b001,
		TW8_WM_CLR_MATCH = 3'b010,
		TW8_WM_FAST_FF = 3'b011,
		TW8_WM_RES4 = 3'b100,
		TW8_WM_PC_CMPA = 3'b101,
		TW8_WM_RES6 = 3'b110,
		TW8_WM_FAST_CMPA = 3'b111
	} tw8_wave_mode_e;

	typedef enum logic [1:0] {
		TW8_KIND_NONPWM = 2'b00,
		TW8_KIND_FAST = 2'b01,
		TW8_KIND_PHASE = 2'b10,
		TW8_KIND_RES = 2'b11
	} tw8_kind_e;

	typedef struct packed {
		logic level;
		logic connect;
		logic enable;
	} tw8_pin_s;

	typedef struct packed {
		logic overflow_flag;
		logic match_b;
		logic match_a;
	} tw8_evt_s;

endpackage : tw8_pkg

// [test/tw8_wave_ctrl_monitor.sv]
// checker: handshake, reset and tick-timing relations at the waveform control ports
`timescale 1ns/1ps
module tw8_wave_ctrl_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic count_tick,
	input wire tw8_pkg::tw8_pin_s pin_a,
	input wire tw8_pkg::tw8_pin_s pin_b,
	input wire tw8_pkg::tw8_evt_s events
);
	import tw8_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
	a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer not held");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("rvalid late");
	a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready during rvalid");
	a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready during bvalid");
	a_reset_idle: assert property ($rose(aresetn) |-> !pin_a.connect && !pin_b.connect && events == 3'h0)
		else $error("not idle after reset");
	a_ovf_on_tick: assert property ($rose(events.overflow_flag) |-> $past(count_tick))
		else $error("overflow without tick");
	a_match_on_tick: assert property ($rose(events.match_a) || $rose(events.match_b) |-> $past(count_tick))
		else $error("match without tick");
	a_level_on_tick: assert property (pin_a.connect && $past(pin_a.connect) && $changed(pin_a.level)
		|-> $past(count_tick)) else $error("compare out moved without tick");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_ovf: cover property ($rose(events.overflow_flag));
	c_both: cover property (pin_a.connect && pin_b.connect);
endmodule : tw8_wave_ctrl_monitor
bind tw8_wave_ctrl tw8_wave_ctrl_monitor u_mon (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .count_tick(count_tick), .pin_a(pin_a),
	.pin_b(pin_b), .events(events));

// [test/tw8_wave_ctrl_bench.sv]
// bench: register-level tests of the waveform control over axi4-lite
`timescale 1ns/1ps
module tw8_wave_ctrl_bench;
	import tw8_pkg::*;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, tick = 0;
	logic [7:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rdat;
	logic awr, wry, bv, arr, rv;
	logic [1:0] br, rr;
	tw8_pin_s pa, pb;
	tw8_evt_s ev;
	int errors = 0, n_compared = 0, ha, hb, k;
	initial forever #2 aclk = ~aclk;
	tw8_wave_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wry),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
		.count_tick(tick), .pin_a(pa), .pin_b(pb), .events(ev));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task end_sim;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// one write; bounded wait, never assumes a response latency
	task wr(input logic [7:0] a, input logic [7:0] d);
		int i;
		logic done;
		logic [1:0] got;
		done = 0;
		@(posedge aclk);
		awa <= a; wd <= {24'h00_0000, d}; awv <= 1; wv <= 1; bry <= 1;
		for (i = 0; i < 64 && !done; i++) begin
			@(posedge aclk);
			if (awv && awr) awv <= 0;
			if (wv && wry) wv <= 0;
			if (bv) begin
				got = br; bry <= 0; done = 1;
			end
		end
		if (!done) begin
			errors++;
			end_sim;
		end
		chk("bresp", {30'h0, TW8_RESP_OKAY}, {30'h0, got});
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
		int i;
		logic done;
		done = 0;
		@(posedge aclk);
		ara <= a; arv <= 1; rry <= 1;
		for (i = 0; i < 64 && !done; i++) begin
			@(posedge aclk);
			if (arv && arr) arv <= 0;
			if (rv) begin
				chk("rdata", e, rdat & m); chk("rresp", {30'h0, er}, {30'h0, rr});
				rry <= 0; done = 1;
			end
		end
		if (!done) begin
			errors++;
			end_sim;
		end
	endtask : rd
	// timer steps; high-time counted over whole periods so latency cannot shift it
	task run(input int n);
		int i;
		ha = 0; hb = 0;
		for (i = 0; i < n; i++) begin
			@(posedge aclk) tick <= 1;
			@(posedge aclk) tick <= 0;
			@(posedge aclk);
			ha += (pa.level === 1'b1); hb += (pb.level === 1'b1);
		end
	endtask : run
	task cfg(input logic [7:0] ca, input logic [7:0] cb, input logic [7:0] ma, input logic [7:0] mb, input int p);
		// compare values pass straight through in normal mode, so park there first
		wr(TW8_OFF_CTRL_B, 8'h01); wr(TW8_OFF_CTRL_A, 8'h00); wr(TW8_OFF_CMP_A, ma); wr(TW8_OFF_CMP_B, mb);
		wr(TW8_OFF_CTRL_B, cb); wr(TW8_OFF_CTRL_A, ca); wr(TW8_OFF_COUNT, 8'h00); run(p); run(p);
	endtask : cfg
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		rd(TW8_OFF_CTRL_A, 32'hFFFF_FFFF, 32'h0000_0000, TW8_RESP_OKAY);
		rd(TW8_OFF_CTRL_B, 32'hFFFF_FFFF, 32'h0000_0000, TW8_RESP_OKAY);
		chk("connect", 32'h0, {pa.connect, pb.connect});
		rd(8'h1C, 32'hFFFF_FFFF, 32'h0000_0000, TW8_RESP_SLVERR);
		$display("test reset done");
		wr(TW8_OFF_CTRL_A, 8'hFF);
		rd(TW8_OFF_CTRL_A, 32'hFFFF_FFFF, 32'h0000_00F3, TW8_RESP_OKAY);
		chk("connect", 32'h3, {pa.connect, pb.connect});
		wr(TW8_OFF_PORT, 8'h10);
		chk("enable", 32'h2, {pa.enable, pb.enable});
		wr(TW8_OFF_CTRL_A, 8'h93);
		chk("connect", 32'h2, {pa.connect, pb.connect});
		wr(TW8_OFF_CTRL_A, 8'h43);
		chk("connect", 32'h0, {pa.connect, pb.connect});
		wr(TW8_OFF_CTRL_A, 8'hF0); wr(TW8_OFF_CTRL_B, 8'h08);
		chk("connect", 32'h0, {pa.connect, pb.connect});
		$display("test pin routing done");
		cfg(8'h00, 8'h01, 8'h03, 8'h05, 1);
		for (k = 0; k < 4; k++) begin
			wr(TW8_OFF_CTRL_A, {2'(k < 3 ? 3 - k : 1), 2'(k < 3 ? 3 - k : 1), 4'h0});
			run(256);
			chk("level", (k % 2 == 0) ? 32'h3 : 32'h0, {30'h0, pa.level, pb.level});
		end
		rd(TW8_OFF_STATUS, 32'h0000_0007, 32'h0000_0007, TW8_RESP_OKAY);
		chk("events", 32'h7, {29'h0, ev});
		wr(TW8_OFF_STATUS, 8'h07);
		rd(TW8_OFF_STATUS, 32'h0000_0007, 32'h0000_0000, TW8_RESP_OKAY);
		chk("events", 32'h0, {29'h0, ev});
		$display("test non-pwm done");
		cfg(8'hA3, 8'h01, 8'h80, 8'hFF, 256);
		chk("high a", 32'd128, 32'(ha));
		chk("high b", 32'd256, 32'(hb));
		cfg(8'hF3, 8'h01, 8'h80, 8'h40, 256);
		chk("high a", 32'd128, 32'(ha));
		chk("high b", 32'd192, 32'(hb));
		cfg(8'h23, 8'h09, 8'h3F, 8'h0F, 64);
		chk("high b", 32'd15, 32'(hb));
		$display("test fast pwm done");
		cfg(8'h12, 8'h01, 8'h0F, 8'h07, 16);
		chk("high b", 32'd7, 32'(hb));
		$display("test clear-on-match done");
		cfg(8'hB1, 8'h01, 8'h80, 8'h40, 510);
		chk("high a", 32'd256, 32'(ha));
		chk("high b", 32'd382, 32'(hb));
		cfg(8'hB1, 8'h09, 8'h40, 8'h20, 128);
		chk("high a", 32'd128, 32'(ha));
		chk("high b", 32'd64, 32'(hb));
		$display("test phase pwm done");
		end_sim;
	end
endmodule : tw8_wave_ctrl_bench
